// ==== verif/aimx_config_regs_tb_top.sv ====
// Testbench for the input mux, bias and reference register bank
module aimx_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic run = 1'b0;
    logic halt = 1'b0;
    logic ext_clk = 1'b0;
    logic exc = 1'b0;
    logic [31:0] prdata, rd;
    logic [31:0] prdata4, rd4;
    logic [7:0] pos4, bias4;
    logic pready, pslverr, er, osc, start, conv, shut, xreq;
    logic [7:0] pos, neg, bias;
    logic b_half, b_two, b_max, ref_on, exc_en, mon_act;
    logic p0, p1, onb, onb_p0;
    logic [2:0] mon_sel;
    int n_mismatch = 0;
    int n_compared = 0;
    always #50 clock = ~clock;
    aimx_core_model model (.clock(clock), .rst_n(rst_n), .run(run),
        .halt(halt), .ext_clk(ext_clk), .exc(exc), .start_pin(start),
        .conversion_active(conv), .shutdown_cmd(shut),
        .ext_osc_active(osc), .excitation_request(xreq));
    aimx_config_regs uut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_osc_active(osc), .start_pin(start),
        .conversion_active(conv), .shutdown_cmd(shut),
        .excitation_request(xreq), .pos_switch_en(pos),
        .neg_switch_en(neg), .bias_enable(bias),
        .burnout_half_ua_en(b_half), .burnout_two_ua_en(b_two),
        .burnout_max_en(b_max), .internal_reference_on(ref_on),
        .excitation_current_en(exc_en), .ref_pair0_sel(p0),
        .ref_pair1_sel(p1), .ref_onboard_sel(onb),
        .ref_onboard_to_pair0(onb_p0), .monitor_active(mon_act),
        .monitor_sel(mon_sel));
    // Four-input variant on the same bus, to reach the absent-input masking
    aimx_config_regs #(.NUM_INPUTS(4)) uut4 (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata4), .pready(),
        .pslverr(), .ext_osc_active(osc), .start_pin(start),
        .conversion_active(conv), .shutdown_cmd(shut),
        .excitation_request(xreq), .pos_switch_en(pos4),
        .neg_switch_en(), .bias_enable(bias4), .burnout_half_ua_en(),
        .burnout_two_ua_en(), .burnout_max_en(),
        .internal_reference_on(), .excitation_current_en(),
        .ref_pair0_sel(), .ref_pair1_sel(), .ref_onboard_sel(),
        .ref_onboard_to_pair0(), .monitor_active(), .monitor_sel());
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Holds the request until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        rd4 = prdata4;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask : rdchk
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        tick(2);
        chk("pos", 32'(pos), 32'h01);
        chk("neg", 32'(neg), 32'h02);
        chk("bias", 32'(bias), 32'h00);
        chk("pair0", 32'(p0), 32'h1);
        rdchk("sel", 8'h00, 32'h01);
        rdchk("bias", 8'h04, 32'h00);
        rdchk("ctrl", 8'h08, 32'h00);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h00, 32'({i[1:0], i[2:0], 3'(7 - i)}));
            apb(1'b1, 8'h04, 32'h1 << i);
            tick(3);
            chk("pos", 32'(pos), 32'h1 << i);
            chk("neg", 32'(neg), 32'h80 >> i);
            chk("bias", 32'(bias), 32'h1 << i);
            chk("pos4", 32'(pos4), (32'h1 << i) & 32'hf);
            chk("bias4", 32'(bias4), (32'h1 << i) & 32'hf);
            chk("burn", 32'({b_max, b_two, b_half}),
                (32'h1 << (i % 4)) >> 1);
            rdchk("bias", 8'h04, 32'h1 << i);
            chk("rdbias4", rd4, (32'h1 << i) & 32'hf);
        end
        // Monitor code 7 must hide the mux and bias choices
        apb(1'b1, 8'h08, 32'hff);
        rdchk("ctrl", 8'h08, 32'h7f);
        tick(3);
        chk("pos", 32'(pos), 32'h0);
        chk("neg", 32'(neg), 32'h0);
        chk("bias", 32'(bias), 32'h0);
        chk("mon", 32'({mon_act, mon_sel}), 32'hf);
        ext_clk <= 1'b1;
        tick(5);
        rdchk("ctrl", 8'h08, 32'hff);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, 8'h08, 32'(j << 3));
            tick(3);
            // Code 11 keeps the onboard select and adds the pair 0 link
            chk("refsel", 32'({onb_p0, onb, p1, p0}),
                (j == 3) ? 32'hc : 32'h1 << j);
        end
        chk("pos", 32'(pos), 32'h80);
        exc <= 1'b1;
        apb(1'b1, 8'h08, 32'h00);
        tick(4);
        chk("ref", 32'(ref_on), 32'h0);
        chk("exc", 32'(exc_en), 32'h0);
        apb(1'b1, 8'h08, 32'h20);
        tick(4);
        chk("ref", 32'(ref_on), 32'h1);
        chk("exc", 32'(exc_en), 32'h1);
        for (int k = 2; k < 4; k++) begin
            apb(1'b1, 8'h08, 32'(k << 5));
            tick(5);
            chk("ref", 32'(ref_on), 32'h0);
            run <= 1'b1;
            tick(8);
            chk("ref", 32'(ref_on), 32'h1);
            chk("exc", 32'(exc_en), 32'h1);
            halt <= 1'b1;
            tick(5);
            chk("ref", 32'(ref_on), 32'h0);
            chk("exc", 32'(exc_en), 32'h0);
            halt <= 1'b0;
            tick(8);
            chk("ref", 32'(ref_on), 32'h1);
            run <= 1'b0;
            tick(6);
            chk("ref", 32'(ref_on), 32'h0);
        end
        // Unmapped and misaligned places answer with an error only
        apb(1'b0, 8'h0c, 32'h0);
        chk("rd", rd, 32'h0);
        chk("ready", 32'(pready), 32'h1);
        chk("err", 32'(er), 32'h1);
        apb(1'b1, 8'h05, 32'h0f);
        chk("err", 32'(er), 32'h1);
        rdchk("bias", 8'h04, 32'h80);
        finish_test;
    end
endmodule : aimx_config_regs_tb_top

// ==== verif/aimx_core_model.sv ====
// Converter core and pin model feeding the register bank's status inputs
module aimx_core_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic halt,
    input wire logic ext_clk,
    input wire logic exc,
    output logic start_pin,
    output logic conversion_active,
    output logic shutdown_cmd,
    output logic ext_osc_active,
    output logic excitation_request
);
    timeunit 1ns;
    timeprecision 1ns;
    logic halt_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            start_pin <= 1'b0;
            conversion_active <= 1'b0;
            shutdown_cmd <= 1'b0;
            ext_osc_active <= 1'b0;
            excitation_request <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            start_pin <= run;
            // Converting only while start is held and not shut down
            conversion_active <= run & start_pin & !halt;
            shutdown_cmd <= halt & !halt_reg;
            halt_reg <= halt;
            ext_osc_active <= ext_clk;
            excitation_request <= exc;
        end
    end
endmodule : aimx_core_model

// ==== verilog/aimx_config_regs.sv ====
// APB register bank steering input mux, bias, burnout and reference
module aimx_config_regs #(
    parameter int NUM_INPUTS = 8,
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_osc_active,
    input wire logic start_pin,
    input wire logic conversion_active,
    input wire logic shutdown_cmd,
    input wire logic excitation_request,
    output logic [7:0] pos_switch_en,
    output logic [7:0] neg_switch_en,
    output logic [7:0] bias_enable,
    output logic burnout_half_ua_en,
    output logic burnout_two_ua_en,
    output logic burnout_max_en,
    output logic internal_reference_on,
    output logic excitation_current_en,
    output logic ref_pair0_sel,
    output logic ref_pair1_sel,
    output logic ref_onboard_sel,
    output logic ref_onboard_to_pair0,
    output logic monitor_active,
    output logic [2:0] monitor_sel
);

    localparam logic [ADDR_W-1:0] ADDR_SEL =
        ADDR_W'({aimx_pkg::IDX_INPUT_SEL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_BIAS =
        ADDR_W'({aimx_pkg::IDX_BIAS, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_CTL =
        ADDR_W'({aimx_pkg::IDX_CLK_REF, 2'b00});
    localparam logic [7:0] INPUT_MASK =
        8'((16'h1 << NUM_INPUTS) - 16'h1);

    logic [7:0] input_select_burnout_ctrl_reg;
    logic [7:0] input_bias_enables_reg;
    logic [6:0] clock_reference_monitor_ctrl_reg;
    logic [1:0] osc_sync_reg;
    logic [1:0] start_sync_reg;
    logic ref_auto_reg;
    logic ref_auto_next;
    logic [31:0] prdata_reg;

    // Bus decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_sel = (paddr == ADDR_SEL);
    wire hit_bias = (paddr == ADDR_BIAS);
    wire hit_ctl = (paddr == ADDR_CTL);
    wire mapped = hit_sel | hit_bias | hit_ctl;
    // Registers are one byte wide, so only lane 0 carries a write
    wire wr_en = access & pwrite & mapped & pstrb[0];
    wire wr_sel = wr_en & hit_sel;
    wire wr_bias = wr_en & hit_bias;
    wire wr_ctl = wr_en & hit_ctl;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    // Field views
    wire [1:0] burnout_current_sel =
        input_select_burnout_ctrl_reg[aimx_pkg::BURNOUT_LSB +: 2];
    wire [2:0] pos_input_sel =
        input_select_burnout_ctrl_reg[aimx_pkg::POS_LSB +: 3];
    wire [2:0] neg_input_sel =
        input_select_burnout_ctrl_reg[aimx_pkg::NEG_LSB +: 3];
    wire [1:0] internal_reference_ctrl =
        clock_reference_monitor_ctrl_reg[aimx_pkg::REFCTRL_LSB +: 2];
    wire [1:0] reference_input_sel =
        clock_reference_monitor_ctrl_reg[aimx_pkg::REFSEL_LSB +: 2];
    wire [2:0] system_monitor_sel =
        clock_reference_monitor_ctrl_reg[aimx_pkg::MON_LSB +: 3];
    wire oscillator_source_flag = osc_sync_reg[1];
    wire mon_normal = (system_monitor_sel == aimx_pkg::MON_NORMAL);

    // Codes naming absent inputs are kept but read as zero
    wire pos_present = INPUT_MASK[pos_input_sel];
    wire neg_present = INPUT_MASK[neg_input_sel];
    wire [2:0] pos_rd = pos_present ? pos_input_sel : 3'h0;
    wire [2:0] neg_rd = neg_present ? neg_input_sel : 3'h0;

    wire [7:0] rd_sel = {burnout_current_sel, pos_rd, neg_rd};
    wire [7:0] rd_bias = input_bias_enables_reg;
    wire [7:0] rd_ctl = {oscillator_source_flag,
                         clock_reference_monitor_ctrl_reg};
    wire [7:0] rd_byte = hit_sel ? rd_sel :
                         hit_bias ? rd_bias :
                         hit_ctl ? rd_ctl : 8'h00;

    // Read data is captured in setup so it is a flop during access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Pin inputs, two stages each before use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_sync_reg <= 2'b00;
            start_sync_reg <= 2'b00;
        end else begin
            osc_sync_reg <= {osc_sync_reg[0], ext_osc_active};
            start_sync_reg <= {start_sync_reg[0], start_pin};
        end
    end

    // Register storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            input_select_burnout_ctrl_reg <= aimx_pkg::RST_INPUT_SEL;
        end else if (wr_sel) begin
            input_select_burnout_ctrl_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            input_bias_enables_reg <= aimx_pkg::RST_BIAS;
        end else if (wr_bias) begin
            input_bias_enables_reg <= pwdata[7:0] & INPUT_MASK;
        end
    end

    // Bit 7 has no storage: writes to it are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clock_reference_monitor_ctrl_reg <= aimx_pkg::RST_CLK_REF;
        end else if (wr_ctl) begin
            clock_reference_monitor_ctrl_reg <= pwdata[6:0];
        end
    end

    // Follow mode: shutdown or start low beats a running conversion
    always_comb begin
        ref_auto_next = ref_auto_reg;
        if (shutdown_cmd || !start_sync_reg[1]) begin
            ref_auto_next = 1'b0;
        end else if (conversion_active) begin
            ref_auto_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_auto_reg <= 1'b0;
        end else begin
            ref_auto_reg <= ref_auto_next;
        end
    end

    wire ref_on_next =
        (internal_reference_ctrl == aimx_pkg::REFCTRL_ON) |
        (internal_reference_ctrl[1] & ref_auto_reg);
    // Same edge as the reference, so current never leads it
    wire exc_next = excitation_request & ref_on_next;

    // Input switches, one per analog input
    logic [7:0] pos_next;
    logic [7:0] neg_next;
    logic [7:0] bias_next;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_input
            if (gi < NUM_INPUTS) begin : g_present
                assign pos_next[gi] =
                    mon_normal & (pos_input_sel == 3'(gi));
                assign neg_next[gi] =
                    mon_normal & (neg_input_sel == 3'(gi));
                assign bias_next[gi] =
                    mon_normal & input_bias_enables_reg[gi];
            end else begin : g_absent
                assign pos_next[gi] = 1'b0;
                assign neg_next[gi] = 1'b0;
                assign bias_next[gi] = 1'b0;
            end
        end
    endgenerate

    wire [2:0] burn_next = {
        burnout_current_sel == aimx_pkg::BURN_MAX,
        burnout_current_sel == aimx_pkg::BURN_TWO,
        burnout_current_sel == aimx_pkg::BURN_HALF};

    wire [3:0] refsel_next = {
        reference_input_sel == aimx_pkg::REFSEL_ONBOARD_PAIR0,
        reference_input_sel[1],
        reference_input_sel == aimx_pkg::REFSEL_PAIR1,
        reference_input_sel == aimx_pkg::REFSEL_PAIR0};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_switch_en <= 8'h00;
            neg_switch_en <= 8'h00;
            bias_enable <= 8'h00;
        end else begin
            pos_switch_en <= pos_next;
            neg_switch_en <= neg_next;
            bias_enable <= bias_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {burnout_max_en, burnout_two_ua_en, burnout_half_ua_en} <= 3'h0;
            {ref_onboard_to_pair0, ref_onboard_sel, ref_pair1_sel,
             ref_pair0_sel} <= 4'h0;
        end else begin
            {burnout_max_en, burnout_two_ua_en, burnout_half_ua_en} <=
                burn_next;
            {ref_onboard_to_pair0, ref_onboard_sel, ref_pair1_sel,
             ref_pair0_sel} <= refsel_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            internal_reference_on <= 1'b0;
            excitation_current_en <= 1'b0;
            monitor_active <= 1'b0;
            monitor_sel <= 3'h0;
        end else begin
            internal_reference_on <= ref_on_next;
            excitation_current_en <= exc_next;
            monitor_active <= ~mon_normal;
            monitor_sel <= system_monitor_sel;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_sel_write_normal;
        wr_sel && mon_normal && !wr_ctl ##1 mon_normal;
    endsequence

    sequence s_bias_write_normal;
        wr_bias && mon_normal && !wr_ctl ##1 mon_normal;
    endsequence

    sequence s_shutdown_in_follow;
        internal_reference_ctrl[1] && shutdown_cmd
            ##1 internal_reference_ctrl[1];
    endsequence

    property p_burnout_half;
        wr_sel && pwdata[7:6] == aimx_pkg::BURN_HALF |-> ##2
            burnout_half_ua_en && !burnout_two_ua_en && !burnout_max_en;
    endproperty
    a_burnout_half: assert property (p_burnout_half)
        else $error("burnout 0.5uA code not driven");

    property p_burnout_max;
        wr_sel && pwdata[7:6] == aimx_pkg::BURN_MAX |-> ##2
            burnout_max_en && !burnout_two_ua_en && !burnout_half_ua_en;
    endproperty
    a_burnout_max: assert property (p_burnout_max)
        else $error("burnout strongest code not driven");

    property p_pos_route;
        s_sel_write_normal |-> ##1
            pos_switch_en == (INPUT_MASK & 8'(8'h01 << $past(pwdata[5:3], 2)));
    endproperty
    a_pos_route: assert property (p_pos_route)
        else $error("positive input routing wrong");

    property p_neg_route;
        s_sel_write_normal |-> ##1
            neg_switch_en == (INPUT_MASK & 8'(8'h01 << $past(pwdata[2:0], 2)));
    endproperty
    a_neg_route: assert property (p_neg_route)
        else $error("negative input routing wrong");

    property p_bias_map;
        s_bias_write_normal |-> ##1
            bias_enable == (INPUT_MASK & $past(pwdata[7:0], 2));
    endproperty
    a_bias_map: assert property (p_bias_map)
        else $error("bias bit does not follow its input");

    property p_bias_clear;
        input_bias_enables_reg == 8'h00 |=> bias_enable == 8'h00;
    endproperty
    a_bias_clear: assert property (p_bias_clear)
        else $error("bias applied with no bit set");

    property p_osc_flag;
        setup && !pwrite && hit_ctl |=>
            prdata[aimx_pkg::OSC_FLAG_BIT] == $past(osc_sync_reg[1]);
    endproperty
    a_osc_flag: assert property (p_osc_flag)
        else $error("oscillator flag readback wrong");

    property p_ref_fixed;
        internal_reference_ctrl == aimx_pkg::REFCTRL_OFF |=>
            !internal_reference_on;
    endproperty
    a_ref_fixed: assert property (p_ref_fixed)
        else $error("reference on while held off");

    property p_ref_shutdown;
        s_shutdown_in_follow |=> !internal_reference_on;
    endproperty
    a_ref_shutdown: assert property (p_ref_shutdown)
        else $error("reference not off after shutdown");

    property p_exc_needs_ref;
        excitation_current_en |-> internal_reference_on;
    endproperty
    a_exc_needs_ref: assert property (p_exc_needs_ref)
        else $error("excitation current without reference");

    property p_ctl_write;
        wr_ctl |=> rd_ctl[6:0] == $past(pwdata[6:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("control register write lost");

    property p_monitor_override;
        !mon_normal |=> pos_switch_en == 8'h00 && neg_switch_en == 8'h00
            && bias_enable == 8'h00 && monitor_active;
    endproperty
    a_monitor_override: assert property (p_monitor_override)
        else $error("monitor did not override inputs");

    property p_refsel_pair0;
        wr_ctl && pwdata[4:3] == aimx_pkg::REFSEL_ONBOARD_PAIR0 |-> ##2
            ref_onboard_sel && ref_onboard_to_pair0 && !ref_pair1_sel
            && !ref_pair0_sel;
    endproperty
    a_refsel_pair0: assert property (p_refsel_pair0)
        else $error("onboard onto pair 0 not selected");

    property p_absent_bits;
        wr_bias |=> (input_bias_enables_reg & ~INPUT_MASK) == 8'h00;
    endproperty
    a_absent_bits: assert property (p_absent_bits)
        else $error("absent input bias bit stored");

endmodule : aimx_config_regs

// ==== verilog/aimx_pkg.sv ====
// Register map, field layout and codes for the input mux and reference block
// Contract
// - Burnout code 00 turns the detect source off, 01 enables 0.5uA, 10 2uA.
// - The positive select code N routes analog input N, default input 0.
// - The negative select code N routes analog input N, default input 1.
// - A set bias bit biases its input to midsupply, all clear after reset.
// - Bias bit 0 serves analog input 0 and higher bits higher inputs.
// - Control bit 7 is read-only and shows 1 while the external clock runs.
// - Reference code 00 keeps the internal reference off and 01 keeps it on.
// - Codes 10/11 power the reference for conversions, off on shutdown/start low.
// - Excitation current sources never run while the reference is off.
// - The control register at index 02h resets to 00h with the set layout.
// - A non-normal monitor selection overrides input selects and bias.
// - Reference select picks pair 0, pair 1, onboard, or onboard onto pair 0.
package aimx_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INPUT_SEL = 8'h00;
    localparam logic [7:0] IDX_BIAS = 8'h01;
    localparam logic [7:0] IDX_CLK_REF = 8'h02;

    localparam logic [7:0] RST_INPUT_SEL = 8'h01;
    localparam logic [7:0] RST_BIAS = 8'h00;
    localparam logic [6:0] RST_CLK_REF = 7'h00;

    localparam int BURNOUT_LSB = 6;
    localparam int POS_LSB = 3;
    localparam int NEG_LSB = 0;
    localparam int OSC_FLAG_BIT = 7;
    localparam int REFCTRL_LSB = 5;
    localparam int REFSEL_LSB = 3;
    localparam int MON_LSB = 0;

    localparam logic [1:0] BURN_OFF = 2'h0;
    localparam logic [1:0] BURN_HALF = 2'h1;
    localparam logic [1:0] BURN_TWO = 2'h2;
    localparam logic [1:0] BURN_MAX = 2'h3;

    localparam logic [1:0] REFCTRL_OFF = 2'h0;
    localparam logic [1:0] REFCTRL_ON = 2'h1;

    localparam logic [1:0] REFSEL_PAIR0 = 2'h0;
    localparam logic [1:0] REFSEL_PAIR1 = 2'h1;
    localparam logic [1:0] REFSEL_ONBOARD = 2'h2;
    localparam logic [1:0] REFSEL_ONBOARD_PAIR0 = 2'h3;

    localparam logic [2:0] MON_NORMAL = 3'h0;

endpackage : aimx_pkg
